// *** i2c_triple_slave_regs.vh ***
`ifndef I2C_TRIPLE_SLAVE_REGS_VH
`define I2C_TRIPLE_SLAVE_REGS_VH
// register indices, byte address is four times the index
`define IDX_CTRL_ONE 10'h060
`define IDX_CTRL_TWO 10'h061
`define IDX_FLAGS 10'h062
`define IDX_COUNT 10'h063
`define IDX_ADDR1 10'h064
`define IDX_OFF1 10'h065
`define IDX_ADDR2 10'h066
`define IDX_OFF2 10'h067
`define IDX_ADDR3 10'h068
`define IDX_OFF3 10'h069
// status bit positions
`define FLG_UNACKED_NO_STOP_FLAG 7
`define FLG_BUS_ERROR_FLAG 6
`define FLG_WR_BASE 3
`define FLG_RD_BASE 0
// control two bit positions
`define CR2_LOCK2 4
`define CR2_LOCK1 3
`define CR2_ON 2
// writable bits of control one, bit 5 reserved
`define CR1_MASK 8'hdf
// reset and cleared values
`define ZERO_BYTE 8'h00
`define ZERO_WORD 32'h0000_0000
// slave 3 buffer holds only 128 bytes
`define SLV3_OFF_MASK 8'h7f
`define FULL_OFF_MASK 8'hff
// i2c engine states
`define ST_IDLE 3'd0
`define ST_ADDR 3'd1
`define ST_ADDR_ACK 3'd2
`define ST_RX 3'd3
`define ST_RX_ACK 3'd4
`define ST_TX 3'd5
`define ST_TX_ACK 3'd6
`define ST_WAIT_STOP 3'd7
// bits in a byte
`define BITS_PER_BYTE 4'd8
`define RAM_WORDS 768
`endif

// *** i2c_triple_slave.v ***
// Added by the designer: register access over APB.
`include "i2c_triple_slave_regs.vh"

module i2c_triple_slave
(
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  output reg [7:0] ctrl_one,
  output reg interface_on,
  output reg slave1_write_lock,
  output reg slave2_write_lock,
  output reg transfer_end_pulse
);

  // ****************************************
  // declarations
  // ****************************************
  reg scl_s1, scl_s2, scl_d; // scl synchroniser and history
  reg sda_s1, sda_s2, sda_d; // sda synchroniser and history
  reg [2:0] state; // engine state
  reg [3:0] bit_cnt; // bits seen in current byte
  reg [7:0] shift; // incoming byte
  reg [7:0] tx_byte; // outgoing byte
  reg [1:0] sel; // active slave, 0 none
  reg is_read; // direction of active transfer
  reg first_byte; // next write byte is the byte address
  reg sda_drive; // pull sda low
  reg [7:0] slave_addr [0:2]; // address registers
  reg [7:0] buffer_offset [0:2]; // current offset per slave
  reg [7:0] transfer_count; // byte counter
  reg unacked_no_stop_flag;
  reg bus_error_flag;
  reg [2:0] write_flags; // slave3..1 write flags
  reg [2:0] read_flags; // slave3..1 read flags
  reg [7:0] buf_mem [0:`RAM_WORDS-1]; // slave buffers
  reg mem_we; // buffer write request
  reg [9:0] mem_wa;
  reg [7:0] mem_wd;
  wire [9:0] reg_idx; // word index of access
  wire apb_done; // access completes this edge
  wire apb_wr, apb_rd;
  wire status_read;
  wire scl_rise, scl_fall, start_cond, stop_cond;
  wire misplaced;
  wire [1:0] slot; // sel minus one
  wire [7:0] cur_off;
  wire [7:0] cur_byte;
  wire [7:0] off_mask;
  wire [2:0] hit; // address match per slave
  wire locked;
  wire [7:0] flag_register;
  reg [2:0] hit_set; // one-hot of first hit
  reg [1:0] hit_sel;
  integer i;

  // ****************************************
  // apb decode
  // ****************************************
  assign reg_idx = paddr[11:2];
  assign apb_done = psel & penable & pready;
  assign apb_wr = apb_done & pwrite;
  assign apb_rd = apb_done & ~pwrite;
  assign status_read = apb_rd & (reg_idx == `IDX_FLAGS);
  assign flag_register = {unacked_no_stop_flag, bus_error_flag, write_flags, read_flags};

  // two cycle access phase, data and error registered
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `ZERO_WORD;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready)
      begin
        prdata <= `ZERO_WORD;
        case (reg_idx)
          `IDX_CTRL_ONE: prdata[7:0] <= ctrl_one;
          `IDX_CTRL_TWO: prdata[7:0] <= {3'b000, slave2_write_lock, slave1_write_lock,
            interface_on, 2'b00};
          `IDX_FLAGS: prdata[7:0] <= flag_register;
          `IDX_COUNT: prdata[7:0] <= transfer_count;
          `IDX_ADDR1: prdata[7:0] <= slave_addr[0];
          `IDX_OFF1: prdata[7:0] <= buffer_offset[0];
          `IDX_ADDR2: prdata[7:0] <= slave_addr[1];
          `IDX_OFF2: prdata[7:0] <= buffer_offset[1];
          `IDX_ADDR3: prdata[7:0] <= slave_addr[2];
          `IDX_OFF3: prdata[7:0] <= buffer_offset[2];
          default: pslverr <= 1'b1; // unmapped
        endcase
      end
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // first write with enable set only turns the interface on
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      interface_on <= 1'b0;
      slave1_write_lock <= 1'b0;
      slave2_write_lock <= 1'b0;
      ctrl_one <= `ZERO_BYTE;
    end
    else
    begin
      if (apb_wr && reg_idx == `IDX_CTRL_TWO)
      begin
        interface_on <= pwdata[`CR2_ON];
        if (interface_on && pwdata[`CR2_ON])
        begin
          slave1_write_lock <= pwdata[`CR2_LOCK1];
          slave2_write_lock <= pwdata[`CR2_LOCK2];
        end
        else
        begin
          slave1_write_lock <= 1'b0;
          slave2_write_lock <= 1'b0;
        end
      end
      if (!interface_on)
        ctrl_one <= `ZERO_BYTE;
      else if (apb_wr && reg_idx == `IDX_CTRL_ONE)
        ctrl_one <= pwdata[7:0] & `CR1_MASK;
    end
  end

  // ****************************************
  // slave address registers
  // ****************************************
  // address in 7:1, respond enable in 0
  always @(posedge core_clk)
  begin
    for (i = 0; i < 3; i = i + 1)
    begin
      if (rst || !interface_on)
        slave_addr[i] <= `ZERO_BYTE;
      else if (apb_wr && reg_idx == `IDX_ADDR1 + 2 * i)
        slave_addr[i] <= pwdata[7:0];
    end
  end

  // ****************************************
  // link synchronisers and conditions
  // ****************************************
  // two flops, then a history flop for edges
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
  // start or stop past a byte's first bit, or in an acknowledge slot
  // the first bit's high phase is where a legal stop or restart shows up
  assign misplaced = (start_cond | stop_cond) &
    ((((state == `ST_ADDR) | (state == `ST_RX) | (state == `ST_TX)) & (bit_cnt > 4'd1)) |
    (state == `ST_ADDR_ACK) | (state == `ST_RX_ACK) | (state == `ST_TX_ACK));

  // scl is never driven; sda only pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_drive;

  // ****************************************
  // slave selection and buffer access
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : match_gen
      assign hit[g] = slave_addr[g][0] & (slave_addr[g][7:1] == shift[7:1]);
    end
  endgenerate

  // lowest numbered matching slave wins
  always @*
  begin
    hit_set = 3'b000;
    hit_sel = 2'd0;
    if (hit[0])
    begin
      hit_set = 3'b001;
      hit_sel = 2'd1;
    end
    else if (hit[1])
    begin
      hit_set = 3'b010;
      hit_sel = 2'd2;
    end
    else if (hit[2])
    begin
      hit_set = 3'b100;
      hit_sel = 2'd3;
    end
  end

  assign slot = sel - 2'd1;
  assign off_mask = (sel == 2'd3) ? `SLV3_OFF_MASK : `FULL_OFF_MASK;
  assign cur_off = buffer_offset[slot];
  assign cur_byte = buf_mem[{slot, cur_off}];
  assign locked = ((sel == 2'd1) & slave1_write_lock) | ((sel == 2'd2) & slave2_write_lock);

  // buffer store port
  always @(posedge core_clk)
  begin
    if (mem_we)
      buf_mem[mem_wa] <= mem_wd;
  end

  // ****************************************
  // i2c engine, offsets, count and flags
  // ****************************************
  always @(posedge core_clk)
  begin
    if (rst || !interface_on)
    begin
      state <= `ST_IDLE;
      bit_cnt <= 4'd0;
      shift <= `ZERO_BYTE;
      tx_byte <= `ZERO_BYTE;
      sel <= 2'd0;
      is_read <= 1'b0;
      first_byte <= 1'b0;
      sda_drive <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
        buffer_offset[i] <= `ZERO_BYTE;
      transfer_count <= `ZERO_BYTE;
      unacked_no_stop_flag <= 1'b0;
      bus_error_flag <= 1'b0;
      write_flags <= 3'b000;
      read_flags <= 3'b000;
      mem_we <= 1'b0;
      mem_wa <= 10'h000;
      mem_wd <= `ZERO_BYTE;
      transfer_end_pulse <= 1'b0;
    end
    else
    begin
      mem_we <= 1'b0;
      transfer_end_pulse <= 1'b0;
      // flag clears by status read, sets below win
      if (status_read)
      begin
        unacked_no_stop_flag <= 1'b0;
        bus_error_flag <= 1'b0;
        if (state == `ST_IDLE)
        begin
          write_flags <= 3'b000;
          read_flags <= 3'b000;
        end
      end
      // software writes to offsets
      for (i = 0; i < 3; i = i + 1)
      begin
        if (apb_wr && reg_idx == `IDX_OFF1 + 2 * i)
          buffer_offset[i] <= pwdata[7:0] & ((i == 2) ? `SLV3_OFF_MASK : `FULL_OFF_MASK);
      end
      if (misplaced)
      begin
        bus_error_flag <= 1'b1;
        sda_drive <= 1'b0;
        state <= `ST_IDLE;
        sel <= 2'd0;
      end
      else if (start_cond || stop_cond)
      begin
        // transfer end, except a write to a locked slave; bus error and refusal error also end it, but without the pulse
        transfer_end_pulse <= (sel != 2'd0) & ~(locked & ~is_read);
        sda_drive <= 1'b0;
        sel <= 2'd0;
        bit_cnt <= 4'd0;
        state <= start_cond ? `ST_ADDR : `ST_IDLE;
      end
      else if (scl_rise)
      begin
        case (state)
          `ST_ADDR, `ST_RX:
          begin
            shift <= {shift[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'd1;
          end
          `ST_TX:
            bit_cnt <= bit_cnt + 4'd1;
          `ST_TX_ACK:
          begin
            if (sda_s2)
            begin
              state <= `ST_WAIT_STOP; // master declined
              bit_cnt <= 4'd0;
            end
          end
          // clock high after refusal, stop or restart may still follow
          `ST_WAIT_STOP:
            bit_cnt <= 4'd1;
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        case (state)
          `ST_ADDR:
          begin
            if (bit_cnt == `BITS_PER_BYTE)
            begin
              if (hit != 3'b000)
              begin
                sda_drive <= 1'b1;
                sel <= hit_sel;
                is_read <= shift[0];
                first_byte <= 1'b1;
                transfer_count <= `ZERO_BYTE;
                if (shift[0])
                  read_flags <= read_flags | hit_set;
                else
                  write_flags <= write_flags | hit_set;
                state <= `ST_ADDR_ACK;
              end
              else
                state <= `ST_IDLE; // not addressed
            end
          end
          `ST_RX:
          begin
            if (bit_cnt == `BITS_PER_BYTE)
            begin
              sda_drive <= 1'b1;
              first_byte <= 1'b0;
              // count runs free of page length
              transfer_count <= transfer_count + 8'd1;
              if (first_byte)
                buffer_offset[slot] <= shift & off_mask;
              else
              begin
                mem_we <= ~locked;
                mem_wa <= {slot, cur_off};
                mem_wd <= shift;
                buffer_offset[slot] <= (cur_off + 8'd1) & off_mask;
              end
              state <= `ST_RX_ACK;
            end
          end
          `ST_RX_ACK:
          begin
            sda_drive <= 1'b0;
            bit_cnt <= 4'd0;
            state <= `ST_RX;
          end
          `ST_ADDR_ACK, `ST_TX_ACK:
          begin
            bit_cnt <= 4'd0;
            if (state == `ST_ADDR_ACK && !is_read)
            begin
              sda_drive <= 1'b0;
              state <= `ST_RX;
            end
            else
            begin
              // send byte at offset, then advance
              tx_byte <= cur_byte;
              sda_drive <= ~cur_byte[7];
              buffer_offset[slot] <= (cur_off + 8'd1) & off_mask;
              state <= `ST_TX;
            end
          end
          `ST_TX:
          begin
            if (bit_cnt == `BITS_PER_BYTE)
            begin
              sda_drive <= 1'b0;
              transfer_count <= transfer_count + 8'd1;
              state <= `ST_TX_ACK;
            end
            else
              sda_drive <= ~tx_byte[3'd7 - bit_cnt[2:0]];
          end
          // pulse ended with no stop or restart: refusal error
          `ST_WAIT_STOP:
          begin
            if (bit_cnt != 4'd0)
            begin
              unacked_no_stop_flag <= 1'b1;
              state <= `ST_IDLE;
              sel <= 2'd0;
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule // i2c_triple_slave

// *** i2c_master_model.sv ***
// ************
// i2c bus master, 160 ns bit period
// ************
module i2c_master_model
(
  output reg scl,
  output reg sda_lo,
  input wire sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus: clock high, data released
  initial
  begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // start or restart, leaves clock low
  task start();
  begin
    sda_lo = 1'b0;
    #47 scl = 1'b1;
    #40 sda_lo = 1'b1;
    #40 scl = 1'b0;
    #40;
  end
  endtask
  // stop, clock stays high after it
  task stop();
  begin
    sda_lo = 1'b1;
    #40 scl = 1'b1;
    #40 sda_lo = 1'b0;
    #40;
  end
  endtask
  // one bit: data set while clock low, sampled mid high
  task bitx(input b, output r);
  begin
    sda_lo = !b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
    #40;
  end
  endtask
  // byte msb first, then acknowledge slot
  task xfer(input [7:0] d, input ai, output [7:0] q, output ao);
    integer i;
  begin
    for (i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(ai, ao);
  end
  endtask
endmodule // i2c_master_model

// *** i2c_triple_slave_properties.sv ***
// ************
// port checker
// ************
module i2c_triple_slave_checker
(
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_n,
  input wire [7:0] ctrl_one,
  input wire interface_on,
  input wire slave1_write_lock,
  input wire slave2_write_lock,
  input wire transfer_end_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // bus phases
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence acc_s;
    psel && penable;
  endsequence
  AST_APB_WAIT: assert property (setup_s ##1 acc_s |-> !pready ##1 pready)
    else $error("ready not on second access cycle");
  AST_READY_IN_ACCESS: assert property (pready |-> acc_s and $past(psel && penable))
    else $error("ready outside access phase");
  AST_ERR_UNMAPPED: assert property
    (pslverr |-> pready && (paddr[11:2] < 10'h060 || paddr[11:2] > 10'h069))
    else $error("error on mapped register");
  AST_COUNT_WIDTH: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above eight bits");
  AST_SLV3_OFF: assert property
    (pready && !pwrite && paddr[11:2] == 10'h069 |-> !prdata[7])
    else $error("slave three offset bit seven set");
  AST_OFF_CLEAR: assert property
    (pready && !pwrite && !interface_on && !pslverr |-> prdata == 32'h0)
    else $error("register not cleared while off");
  AST_OFF_QUIET: assert property
    (!interface_on && !$past(interface_on) |->
    sda_oe_n && ctrl_one == 8'h00 && !slave1_write_lock && !slave2_write_lock)
    else $error("activity while interface off");
  AST_ENABLE_FIRST: assert property
    ($rose(interface_on) |-> !slave1_write_lock && !slave2_write_lock)
    else $error("locks loaded by first enable");
  AST_PULSE_ONE: assert property
    (transfer_end_pulse |=> !transfer_end_pulse [*8])
    else $error("end pulse repeated");
  AST_SDA_OUT_ZERO: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe_n) |-> !$past(scl_in))
    else $error("data changed while clock high");
endmodule // i2c_triple_slave_checker

bind i2c_triple_slave i2c_triple_slave_checker i2c_triple_slave_checker_i
  (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .scl_in, .sda_in, .sda_out, .sda_oe_n, .ctrl_one, .interface_on,
   .slave1_write_lock, .slave2_write_lock, .transfer_end_pulse);

// *** test_i2c_triple_slave.sv ***
// ************
// testbench
// ************
module test_i2c_triple_slave;
  timeunit 1ns;
  timeprecision 100ps;
  reg core_clk, rst, psel, penable, pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, sda_out, sda_oe_n, interface_on, scl, sda_lo;
  wire slave1_write_lock, slave2_write_lock, transfer_end_pulse;
  wire [7:0] ctrl_one;
  // pulled-up data line
  wire sda = !(sda_lo || (!sda_oe_n && !sda_out));
  integer failures, cmp_count, i, s, j, n;
  reg [7:0] lf, q, off, acc, ev, e0;
  reg [7:0] dv [1:3];
  reg [7:0] base [1:3];
  reg [6:0] ad [1:3];
  reg e, ak;
  i2c_triple_slave i2c_triple_slave_i (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ctrl_one(ctrl_one),
    .interface_on(interface_on), .slave1_write_lock(slave1_write_lock),
    .slave2_write_lock(slave2_write_lock), .transfer_end_pulse(transfer_end_pulse));
  i2c_master_model i2c_master_model_i (.scl(scl), .sda_lo(sda_lo), .sda(sda));
  always #10 core_clk = ~core_clk;
  // count transfer ends
  always @(posedge core_clk)
    if (transfer_end_pulse === 1'b1)
      ev <= ev + 8'h01;
  function [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // one bus transfer, held until ready
  task apb(input w, input [11:0] a, input [7:0] d, output [7:0] r, output x);
    integer k;
  begin
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk) penable <= 1'b1;
    k = 0;
    @(posedge core_clk);
    while (pready !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge core_clk);
    end
    if (k == 20)
    begin
      failures++;
      $display("CHECK FAILED at %0t: bus access timed out", $time);
    end
    r = prdata[7:0];
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  end
  endtask
  task chk(input [7:0] g, input [7:0] x);
  begin
    cmp_count++;
    if (g !== x)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, x);
    end
  end
  endtask
  task rd(input [11:0] a, input [7:0] x);
  begin
    apb(1'b0, a, 8'h00, q, e);
    chk(q, x);
  end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  // byte to the slave, acks gathered
  task sb(input [7:0] d);
  begin
    i2c_master_model_i.xfer(d, 1'b1, q, ak);
    acc = acc | {7'h0, ak};
  end
  endtask
  task zeros();
    for (i = 0; i < 10; i++)
      rd(12'h180 + 4 * i, 8'h00);
  endtask
  task conclude();
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // watchdog
  initial
  begin
    #1500000;
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end
  // ************
  // main sequence
  // ************
  initial
  begin
    core_clk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    lf = 8'h4f; failures = 0; cmp_count = 0; ev = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    zeros();
    apb(1'b0, 12'h1a8, 8'h00, q, e);
    chk({7'h0, e}, 8'h01);
    $display("test reset done");
    wr(12'h184, 8'h1c);
    chk({6'h0, slave2_write_lock, slave1_write_lock}, 8'h00);
    wr(12'h184, 8'h04);
    chk({7'h0, interface_on}, 8'h01);
    wr(12'h180, 8'h1f);
    chk(ctrl_one, 8'h1f);
    for (s = 1; s <= 3; s++)
    begin
      lf = lfsr(lf);
      ad[s] = lf[6:0] ^ s[6:0];
      wr(12'h188 + 8 * s, {ad[s], 1'b1});
      rd(12'h188 + 8 * s, {ad[s], 1'b1});
    end
    $display("test setup done");
    for (s = 1; s <= 3; s++)
    begin
      lf = lfsr(lf);
      off = (s == 3) ? 8'h80 : lf;
      n = (s == 2) ? 17 : 1;
      acc = 0;
      i2c_master_model_i.start();
      sb({ad[s], 1'b0});
      sb(off);
      for (j = 0; j < n; j++)
      begin
        lf = lfsr(lf);
        if (j == 0)
          dv[s] = lf;
        sb(lf);
      end
      i2c_master_model_i.stop();
      chk(acc, 8'h00);
      base[s] = (s == 3) ? off & 8'h7f : off;
      rd(12'h18c + 8 * s, base[s] + n[7:0] & ((s == 3) ? 8'h7f : 8'hff));
      rd(12'h18c, n[7:0] + 8'h01);
      rd(12'h188, 8'h04 << s);
      rd(12'h188, 8'h00);
    end
    chk(ev, 8'h03);
    $display("test writes done");
    i2c_master_model_i.start();
    sb({ad[1], 1'b0});
    sb(base[1]);
    i2c_master_model_i.start();
    sb({ad[1], 1'b1});
    i2c_master_model_i.xfer(8'hff, 1'b1, q, ak);
    chk(q, dv[1]);
    i2c_master_model_i.stop();
    rd(12'h194, base[1] + 8'h01);
    rd(12'h18c, 8'h01);
    rd(12'h188, 8'h09);
    chk(ev, 8'h05);
    $display("test read done");
    wr(12'h19c, base[2]);
    i2c_master_model_i.start();
    sb({ad[2], 1'b1});
    i2c_master_model_i.xfer(8'hff, 1'b1, q, ak);
    chk(q, dv[2]);
    i2c_master_model_i.bitx(1'b1, ak);
    i2c_master_model_i.stop();
    rd(12'h188, 8'h82);
    rd(12'h188, 8'h00);
    i2c_master_model_i.start();
    i2c_master_model_i.bitx(1'b1, ak);
    i2c_master_model_i.bitx(1'b0, ak);
    i2c_master_model_i.start();
    i2c_master_model_i.stop();
    rd(12'h188, 8'h40);
    rd(12'h188, 8'h00);
    $display("test errors done");
    wr(12'h1a0, {ad[3], 1'b0});
    acc = 0;
    i2c_master_model_i.start();
    sb({ad[3], 1'b0});
    i2c_master_model_i.stop();
    chk(acc, 8'h01);
    rd(12'h188, 8'h00);
    wr(12'h184, 8'h0c);
    chk({7'h0, slave1_write_lock}, 8'h01);
    e0 = ev;
    lf = lfsr(lf);
    acc = 0;
    i2c_master_model_i.start();
    sb({ad[1], 1'b0});
    sb(lf);
    sb(8'h5a);
    i2c_master_model_i.stop();
    chk(acc, 8'h00);
    rd(12'h194, lf + 8'h01);
    rd(12'h18c, 8'h02);
    chk(ev, e0);
    $display("test lock done");
    wr(12'h184, 8'h00);
    zeros();
    chk({7'h0, interface_on}, 8'h00);
    $display("test disable done");
    conclude();
  end
endmodule // test_i2c_triple_slave
